/* hw/wdcm_pkg.sv */
// Constants for the windowed watchdog and clock monitor.
// Assumes an idle-timer tick and an instruction-cycle tick from core logic.
// Contract
// - Watchdog active only when option bit selects
// - Enforce upper and lower service limits
// - Count limits in idle-timer clocks
// - Clock monitor flags missing or slow clock
// - Upper and lower checkers are independent
// - Fields: window 7:6, key 5:1, monitor 0
// - Lower limit fixed at 2048 ticks
// - Bits 7:6 choose one of four upper limits
// - Key field must equal 01100
// - Bit 0 enables clock monitor checking
// - Codes 00..11 give 8k,16k,32k,64k upper limit
// - One configuring write; later writes match exactly
// - Error on late service or early service
// - Inhibited in reset; leaves with max window, monitor on
package wdcm_pkg;
  localparam int WIN_HI = 7;
  localparam int WIN_LO = 6;
  localparam int KEY_HI = 5;
  localparam int KEY_LO = 1;
  localparam int CMON_BIT = 0;
  localparam logic [4:0] KEY_VALUE = 5'h0c;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic [16:0] LOWER_LIMIT = 17'h0_0800;
  localparam logic [16:0] UPPER_8K = 17'h0_2000;
  localparam logic [16:0] UPPER_16K = 17'h0_4000;
  localparam logic [16:0] UPPER_32K = 17'h0_8000;
  localparam logic [16:0] UPPER_64K = 17'h1_0000;
  // Clock monitor: ref clocks allowed between instruction-cycle ticks
  localparam int CMON_PERIOD_US = 200;
  localparam int CLK_MHZ = 125;
  localparam int CMON_CYCLES = CMON_PERIOD_US * CLK_MHZ;
  // Output held low this many idle ticks after error clears
  localparam logic [4:0] HOLD_TICKS = 5'h10;
endpackage

/* hw/wdcm_top.sv */
// Windowed watchdog with clock monitor and service register.
// Assumes wr_en/wr_data come from the core on ref_clk; ticks are
// single-cycle pulses on ref_clk, the option strap from a pin.
`timescale 1ns/100ps
module wdcm_top #(
  parameter int CMON_LIMIT = wdcm_pkg::CMON_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire logic wd_option_n, // Option strap, low selects watchdog
  input wire logic idle_timer_tick, // Idle timer clock pulse
  input wire logic icycle_tick, // Instruction-cycle clock pulse
  input wire logic wr_en, // Service register write strobe
  input wire logic [7:0] wr_data, // Service register write data
  output logic [7:0] rd_data, // Service register read data
  output logic watchdog_error_output_n, // Error output, active low
  output logic error_pulse // One cycle on a new error while the output is high
);
  logic opt_s1_q, opt_s2_q, wd_enable_q;
  logic [1:0] win_q;
  logic cmon_en_q, configured_q;
  logic [16:0] lower_cnt_q, upper_cnt_q, upper_limit;
  logic lower_done;
  logic [$clog2(CMON_LIMIT+1)-1:0] cmon_cnt_q;
  logic cmon_fail_q;
  logic [4:0] hold_cnt_q;
  logic out_low_q, err_pulse_q;
  logic key_ok, fields_ok, svc_ok, svc_bad, early, late, fire;

  // Strap synchroniser; enable caught after release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      opt_s1_q <= 1'b1; // Idle level of the strap: watchdog not selected
      opt_s2_q <= 1'b1;
      wd_enable_q <= 1'b0;
    end else if (clk_en) begin
      opt_s1_q <= wd_option_n;
      opt_s2_q <= opt_s1_q;
      wd_enable_q <= ~opt_s2_q;
    end
  end

  // Decode of a service write
  assign key_ok = wr_data[wdcm_pkg::KEY_HI:wdcm_pkg::KEY_LO] == wdcm_pkg::KEY_VALUE;
  assign fields_ok = key_ok && wr_data[wdcm_pkg::WIN_HI:wdcm_pkg::WIN_LO] == win_q
    && wr_data[wdcm_pkg::CMON_BIT] == cmon_en_q;
  assign lower_done = lower_cnt_q >= wdcm_pkg::LOWER_LIMIT;
  // Writes while the output is low are ignored
  assign svc_ok = wd_enable_q && wr_en && !out_low_q
    && (configured_q ? fields_ok : key_ok);
  assign svc_bad = wd_enable_q && wr_en && !out_low_q
    && !(configured_q ? fields_ok : key_ok);
  assign early = svc_ok && configured_q && !lower_done;

  // Window and monitor fields, fixed by the first good write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      win_q <= wdcm_pkg::WIN_RESET;
      cmon_en_q <= 1'b1;
      configured_q <= 1'b0;
    end else if (clk_en && svc_ok && !configured_q) begin
      win_q <= wr_data[wdcm_pkg::WIN_HI:wdcm_pkg::WIN_LO];
      cmon_en_q <= wr_data[wdcm_pkg::CMON_BIT];
      configured_q <= 1'b1;
    end
  end

  // Upper limit lookup
  always_comb begin
    unique case (win_q)
      2'h0: upper_limit = wdcm_pkg::UPPER_8K;
      2'h1: upper_limit = wdcm_pkg::UPPER_16K;
      2'h2: upper_limit = wdcm_pkg::UPPER_32K;
      2'h3: upper_limit = wdcm_pkg::UPPER_64K;
    endcase
  end

  // Lower limit checker: saturates once the lower bound has passed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lower_cnt_q <= '0;
    end else if (clk_en) begin
      if (svc_ok || out_low_q || !wd_enable_q) begin
        lower_cnt_q <= '0;
      end else if (idle_timer_tick && !lower_done) begin
        lower_cnt_q <= lower_cnt_q + 17'h0_0001;
      end
    end
  end

  // Upper limit checker, independent of the lower one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_cnt_q <= '0;
    end else if (clk_en) begin
      if (svc_ok || out_low_q || !wd_enable_q) begin
        upper_cnt_q <= '0;
      end else if (idle_timer_tick && upper_cnt_q < upper_limit) begin
        upper_cnt_q <= upper_cnt_q + 17'h0_0001;
      end
    end
  end
  assign late = wd_enable_q && !out_low_q && upper_cnt_q >= upper_limit;

  // Clock monitor: timeout on gap between instruction-cycle ticks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmon_cnt_q <= '0;
      cmon_fail_q <= 1'b0;
    end else if (clk_en) begin
      if (icycle_tick || !cmon_en_q) begin
        cmon_cnt_q <= '0;
        cmon_fail_q <= 1'b0;
      end else if (cmon_cnt_q >= ($bits(cmon_cnt_q))'(CMON_LIMIT)) begin
        cmon_fail_q <= 1'b1;
      end else begin
        cmon_cnt_q <= cmon_cnt_q + 1'b1;
      end
    end
  end

  assign fire = svc_bad || early || late || cmon_fail_q;

  // Output stretch: low while error, then a fixed hold of idle ticks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_low_q <= 1'b0;
      watchdog_error_output_n <= 1'b1;
      hold_cnt_q <= '0;
      err_pulse_q <= 1'b0;
    end else if (clk_en) begin
      err_pulse_q <= fire && !out_low_q;
      if (fire) begin
        out_low_q <= 1'b1;
        watchdog_error_output_n <= 1'b0;
        hold_cnt_q <= '0;
      end else if (out_low_q && idle_timer_tick) begin
        if (hold_cnt_q == wdcm_pkg::HOLD_TICKS - 5'h01) begin
          out_low_q <= 1'b0;
          watchdog_error_output_n <= 1'b1;
        end
        hold_cnt_q <= hold_cnt_q + 5'h01;
      end
    end
  end
  assign error_pulse = err_pulse_q;

  // Readback: key field always reads as zeros
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= {win_q, 5'h00, cmon_en_q};
    end
  end

  // Checks; helper logic below exists only to give the assertions a view
  // Steps of a service: the write is taken, then the window restarts
  sequence s_svc_taken;
    clk_en && svc_ok;
  endsequence

  sequence s_window_restarted;
    lower_cnt_q == '0 && upper_cnt_q == '0;
  endsequence

  // Steps of an error: a fresh cause, then the pin drops with a pulse
  sequence s_error_cause;
    clk_en && fire && !out_low_q;
  endsequence

  sequence s_pin_dropped;
    out_low_q && !watchdog_error_output_n && error_pulse;
  endsequence

  // Idle ticks since the window opened, one bit wider than the counters
  logic [17:0] chk_ticks_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_ticks_q <= '0;
    end else if (clk_en) begin
      if (svc_ok || out_low_q || !wd_enable_q) begin
        chk_ticks_q <= '0;
      end else if (idle_timer_tick) begin
        chk_ticks_q <= chk_ticks_q + 18'h0_0001;
      end
    end
  end

  // Early service drops the pin
  a_early_errors: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && early |=> out_low_q)
    else $error("early service not flagged");

  // Missing service drops the pin
  a_late_errors: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && late |=> out_low_q)
    else $error("late service not flagged");

  // Mismatching write drops the pin
  a_badkey_errors: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && svc_bad |=> out_low_q)
    else $error("bad write not flagged");

  // Both counters cleared by a good service
  a_restart_counts: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && svc_ok |=> lower_cnt_q == '0 && upper_cnt_q == '0)
    else $error("service did not restart");

  // Fields frozen once configured
  a_config_once: assert property (@(posedge ref_clk) disable iff (rst)
    configured_q |=> $stable(win_q) && $stable(cmon_en_q))
    else $error("config changed");

  // Lower counter saturates at its bound
  a_lower_cap: assert property (@(posedge ref_clk) disable iff (rst)
    lower_cnt_q <= wdcm_pkg::LOWER_LIMIT)
    else $error("lower counter overrun");

  // Upper counter never passes the widest window
  a_upper_cap: assert property (@(posedge ref_clk) disable iff (rst)
    upper_cnt_q <= wdcm_pkg::UPPER_64K)
    else $error("upper counter overrun");

  // Deselected watchdog keeps both measurements at zero
  a_option_off: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !wd_enable_q |=> lower_cnt_q == '0 && upper_cnt_q == '0)
    else $error("active while disabled");

  // Monitor silent when switched off
  a_cmon_off: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !cmon_en_q |=> !cmon_fail_q)
    else $error("monitor active when off");

  // Key never visible on readback
  a_key_read: assert property (@(posedge ref_clk) disable iff (rst)
    rd_data[5:1] == 5'h00)
    else $error("key visible");

  // Service restarts the window, built from its steps
  a_svc_restart: assert property (@(posedge ref_clk) disable iff (rst)
    s_svc_taken |=> s_window_restarted)
    else $error("window not restarted");

  // Fresh error drops the pin and pulses, built from its steps
  a_error_drop: assert property (@(posedge ref_clk) disable iff (rst)
    s_error_cause |=> s_pin_dropped)
    else $error("error not signalled");

  // Pin is the registered image of the error state
  a_pin_follows: assert property (@(posedge ref_clk) disable iff (rst)
    watchdog_error_output_n == !out_low_q)
    else $error("pin disagrees with error state");

  // Error pulse lasts one enabled cycle
  a_pulse_single: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && error_pulse |=> !error_pulse)
    else $error("error pulse too long");

  // Clock enable low freezes the watchdog state
  a_freeze_state: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(lower_cnt_q) && $stable(upper_cnt_q) && $stable(out_low_q))
    else $error("state moved while frozen");

  // Lower counter moves only on idle ticks
  a_lower_step: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wd_enable_q && !out_low_q && !svc_ok && !idle_timer_tick
    |=> $stable(lower_cnt_q))
    else $error("lower count without tick");

  // Upper counter moves only on idle ticks
  a_upper_step: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wd_enable_q && !out_low_q && !svc_ok && !idle_timer_tick
    |=> $stable(upper_cnt_q))
    else $error("upper count without tick");

  // Code 00 selects the narrowest window
  a_select_min: assert property (@(posedge ref_clk) disable iff (rst)
    win_q == 2'h0 |-> upper_limit == wdcm_pkg::UPPER_8K)
    else $error("window 00 wrong limit");

  // Code 11 selects the widest window
  a_select_max: assert property (@(posedge ref_clk) disable iff (rst)
    win_q == 2'h3 |-> upper_limit == wdcm_pkg::UPPER_64K)
    else $error("window 11 wrong limit");

  // Service inside the lower bound is an error
  a_early_window: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && svc_ok && configured_q && lower_cnt_q < wdcm_pkg::LOWER_LIMIT
    |=> out_low_q)
    else $error("lower bound not enforced");

  // First good write configures the register
  a_first_config: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && svc_ok && !configured_q |=> configured_q)
    else $error("first write not taken");

  // Writes while the pin is low change nothing
  a_refused_low: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && out_low_q && wr_en |=> $stable(configured_q) && $stable(win_q))
    else $error("write taken while low");

  // Clock failure drops the pin
  a_cmon_fire: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && cmon_fail_q |=> out_low_q)
    else $error("clock failure not flagged");

  // Monitor counter stays within its limit
  a_cmon_count: assert property (@(posedge ref_clk) disable iff (rst)
    cmon_cnt_q <= CMON_LIMIT)
    else $error("monitor counter overrun");

  // Readback shows the stored window
  a_rd_window: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> rd_data[7:6] == $past(win_q))
    else $error("window readback wrong");

  // Readback shows the stored monitor enable
  a_rd_monitor: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> rd_data[0] == $past(cmon_en_q))
    else $error("monitor readback wrong");

  // Pin released after the hold has run out
  a_hold_release: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && out_low_q && !fire && idle_timer_tick
    && hold_cnt_q == wdcm_pkg::HOLD_TICKS - 5'h01 |=> !out_low_q)
    else $error("hold did not end");

  // No window outlives its upper limit without an error
  a_window_bound: assert property (@(posedge ref_clk) disable iff (rst)
    chk_ticks_q <= {1'b0, upper_limit} + 18'h0_0001)
    else $error("window outlived limit");
endmodule

/* verif/tb_wdcm_top.sv */
// Self-checking bench for the windowed watchdog with clock monitor.
// Assumes wdcm_pkg and wdcm_top are compiled first; one clock, no partner.
`timescale 1ns/100ps
module tb_wdcm_top;
  logic ref_clk = 0, rst = 1, clk_en = 1, wd_option_n = 1, idle_timer_tick = 0;
  logic icycle_tick = 0, wr_en = 0, cm_off = 0, cfg_ok = 0;
  logic [7:0] wr_data = 8'h00, cfg = 8'h00, rd_data;
  logic watchdog_error_output_n, error_pulse;
  logic [31:0] seed = 32'h0000_cb68;
  int n_mismatch = 0, tests_run = 0, since = 0;
  wdcm_top #(.CMON_LIMIT(50)) i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .wd_option_n(wd_option_n), .idle_timer_tick(idle_timer_tick),
    .icycle_tick(icycle_tick), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
    .watchdog_error_output_n(watchdog_error_output_n), .error_pulse(error_pulse));
  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;
  // Instruction-cycle pulses every other cycle; stopping them starves the monitor
  always @(posedge ref_clk) icycle_tick <= !cm_off && !icycle_tick;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Idle ticks; the model counts them since the window start
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk) idle_timer_tick <= 1'b1;
      @(posedge ref_clk) idle_timer_tick <= 1'b0;
      @(negedge ref_clk);
      since++;
    end
  endtask
  // Bounded wait for the output to release; window restarts there
  task automatic recover();
    int i;
    for (i = 0; i < 100 && watchdog_error_output_n !== 1'b1; i++) begin
      tick(1);
    end
    if (i == 100) begin
      chk("recovery", 8'h00, 8'h01);
      report_and_stop();
    end
    since = 0;
  endtask
  // Service write; the model predicts refusal or acceptance
  task automatic wr(input logic [7:0] d);
    logic bad;
    bad = cfg_ok ? (d !== cfg || since < 2048) : (d[5:1] !== 5'b01100);
    if (wd_option_n) bad = 1'b0;
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
    chk("error_n", {7'h0, watchdog_error_output_n}, {7'h0, !bad});
    chk("error_pulse", {7'h0, error_pulse}, {7'h0, bad});
    if (!bad && !wd_option_n) begin
      cfg = d;
      cfg_ok = 1'b1;
      since = 0;
      @(posedge ref_clk);
      #1;
      chk("rd_data", rd_data, {d[7:6], 5'h00, d[0]});
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    chk("reset rd_data", rd_data, 8'h00);
    chk("reset error_n", {7'h0, watchdog_error_output_n}, 8'h01);
    rst <= 1'b0;
    repeat (4) begin
      seed = xs(seed);
      wr(seed[7:0]);
    end
    wd_option_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    // Monitor is on out of reset, so a stopped clock must be caught
    cm_off <= 1'b1;
    repeat (80) @(posedge ref_clk);
    #1;
    chk("monitor error_n", {7'h0, watchdog_error_output_n}, 8'h00);
    cm_off <= 1'b0;
    recover();
    wr(8'h18);
    wr(8'h18);
    recover();
    tick(2040);
    wr(8'h18);
    recover();
    tick(2050);
    wr(8'h18);
    tick(2050);
    wr(8'h58);
    recover();
    tick(8180);
    chk("before upper", {7'h0, watchdog_error_output_n}, 8'h01);
    tick(20);
    chk("after upper", {7'h0, watchdog_error_output_n}, 8'h00);
    report_and_stop();
  end
endmodule
